// *** hw/lcr_pkg.sv ***
/*
   Package for the display controller register bank: offsets, field
   positions, reset values and the bus state encoding.
   Assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
package lcr_pkg;

   // Address decode width and register offsets
   localparam int unsigned ADDR_W       = 12;
   localparam logic [11:0] OFF_CTRL0    = 12'h000;
   localparam logic [11:0] OFF_CTRL1    = 12'h004;
   localparam logic [11:0] OFF_CTRL2    = 12'h008;
   localparam logic [11:0] OFF_CTRL3    = 12'h00c;
   localparam logic [11:0] OFF_STATUS   = 12'h038;
   localparam logic [11:0] OFF_DMA_BASE = 12'h200;
   localparam logic [11:0] OFF_PAL_BASE = 12'h400;

   // Array sizes and descriptor word indices
   localparam int unsigned DMA_REGS     = 10;
   localparam int unsigned PAL_ENTRIES  = 256;
   localparam int unsigned PAL_W        = 16;
   localparam logic [3:0]  DMA_DESC_CH0 = 4'h0;
   localparam logic [3:0]  DMA_DESC_CH1 = 4'h5;

   // First control register fields
   localparam int unsigned C0_ON        = 0;
   localparam int unsigned C0_MONO      = 1;
   localparam int unsigned C0_DUAL      = 2;
   localparam int unsigned C0_LDM       = 3;
   localparam int unsigned C0_SFM       = 4;
   localparam int unsigned C0_IUM       = 5;
   localparam int unsigned C0_EFM       = 6;
   localparam int unsigned C0_PAS       = 7;
   localparam int unsigned C0_DPD       = 9;
   localparam int unsigned C0_DIS       = 10;
   localparam int unsigned C0_QDM       = 11;
   localparam int unsigned C0_SPACE_LSB = 12;
   localparam int unsigned SPACE_W      = 8;
   localparam int unsigned C0_BM        = 20;
   localparam int unsigned C0_OUM       = 21;
   localparam logic [31:0] C0_WR_MASK   = 32'h003f_faff;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

   // Bias toggle count field in the fourth control register
   localparam int unsigned C3_BIAS_LSB  = 0;
   localparam int unsigned BIAS_W       = 8;

   // Status flag positions
   localparam int unsigned ST_IN_OVR    = 0;
   localparam int unsigned ST_IN_UNR    = 1;
   localparam int unsigned ST_OUT_OVR   = 2;
   localparam int unsigned ST_OUT_UNR   = 3;
   localparam int unsigned ST_BUS_ERR   = 4;
   localparam int unsigned ST_FR_START  = 5;
   localparam int unsigned ST_FR_END    = 6;
   localparam int unsigned ST_DIS_DONE  = 7;
   localparam int unsigned ST_BIAS      = 8;
   localparam int unsigned ST_BRANCH    = 9;
   localparam int unsigned ST_QDIS      = 10;
   localparam int unsigned ST_W         = 11;
   localparam logic [10:0] STATUS_RST   = 11'h000;

   // Bus data-phase states, Gray along idle, write, read wait, read out
   typedef enum logic [1:0] {
      BUS_IDLE    = 2'b00,
      BUS_WR      = 2'b01,
      BUS_RD_WAIT = 2'b11,
      BUS_RD_OUT  = 2'b10
   } lcr_bus_t;

   localparam logic [2:0]  HSIZE_WORD   = 3'b010;

endpackage

// *** hw/lcr_pal_if.sv ***
/*
   Interface between the register bank and its palette request spacer.
   Assumes both ends run on the bank clock.
*/
`timescale 1ns/1ps
interface lcr_pal_if;
   logic       req;       // Raw palette fetch request
   logic [7:0] spacing;   // Minimum idle cycles after a grant
   logic       grant;     // Request passed to the bus

   modport spacer (input req, input spacing, output grant);
   modport bank   (output req, output spacing, input grant);
endinterface

// *** hw/lcr_spacer.sv ***
/*
   Palette request spacer: passes a fetch request only after the
   programmed number of idle cycles since the previous grant.
   Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module lcr_spacer
(
   input wire logic hclk,
   input wire logic hresetn,
   lcr_pal_if.spacer p
);
   typedef struct packed {
      logic [7:0] cnt;   // Idle cycles still to wait
   } lcr_sp_st_t;

   lcr_sp_st_t s_q;      // Registered state
   lcr_sp_st_t s_d;      // Next state

   // Grant only when the gap has run out
   assign p.grant = p.req && (s_q.cnt == 8'h00);

   // Reload gap on grant, else count down
   always_comb
   begin
      s_d = s_q;
      if (p.grant)
      begin
         s_d.cnt = p.spacing;
      end
      else if (s_q.cnt != 8'h00)
      begin
         s_d.cnt = s_q.cnt - 8'h01;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   AST_SPACE_GAP: assert property (@(posedge hclk) disable iff (!hresetn)
      (p.grant && p.spacing != 8'h00) |=> !p.grant)
      else $error("palette grant repeated inside the spacing gap");

endmodule

// *** hw/lcr_bank.sv ***
/*
   Display controller register bank: four control registers, ten DMA
   registers, a status register and a 256-entry palette on AHB-Lite.
   Assumes display engine events arrive as one-cycle pulses on hclk
   and that the bank is the only slave driving hready.
*/
`timescale 1ns/1ps

module lcr_bank
   import lcr_pkg::*;
(
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic [31:0]                        hrdata,
   input  wire logic                          ev_in_fifo_overrun,
   input  wire logic                          ev_in_fifo_underrun,
   input  wire logic                          ev_out_fifo_overrun,
   input  wire logic                          ev_out_fifo_underrun,
   input  wire logic                          ev_bus_error,
   input  wire logic                          ev_frame_start,
   input  wire logic                          ev_frame_end,
   input  wire logic                          ev_branch_start,
   input  wire logic                          ev_quick_disable,
   input  wire logic                          ev_last_frame_out,
   input  wire logic                          bias_pin,
   input  wire logic                          dma_load_en,
   input  wire logic [3:0]                    dma_load_idx,
   input  wire logic [31:0]                   dma_load_data,
   input  wire logic                          pal_fetch_req,
   output logic                               pal_fetch_grant,
   input  wire logic [7:0]                    pal_rd_idx,
   output logic [lcr_pkg::PAL_W-1:0]          pal_rd_data,
   output logic [31:0]                        display_control_0,
   output logic [31:0]                        display_control_1,
   output logic [31:0]                        display_control_2,
   output logic [31:0]                        display_control_3,
   output logic [lcr_pkg::DMA_REGS-1:0][31:0] dma_regs,
   output logic                               controller_on,
   output logic                               irq
);
   import lcr_pkg::*;

   // All bank state but the palette, its read port and the spacer counter in one record
   typedef struct packed {
      lcr_bus_t                     bus;       // Data-phase state
      logic [ADDR_W-1:0]            addr;      // Latched address
      logic                         size_ok;   // Latched word size
      logic [31:0]                  ctrl0;     // First control register
      logic [31:0]                  ctrl1;     // Second control register
      logic [31:0]                  ctrl2;     // Third control register
      logic [31:0]                  ctrl3;     // Fourth control register
      logic [ST_W-1:0]              status;    // Sticky event flags
      logic [DMA_REGS-1:0][31:0]    dma;       // DMA registers
      logic                         dis;       // Disabled or disabling
      logic                         pend;      // Waiting for last frame
      logic                         bias_prev; // Bias pin last cycle
      logic [BIAS_W-1:0]            bias_cnt;  // Toggles so far
      logic [31:0]                  rdata;     // Read data register
   } lcr_st_t;

   lcr_st_t                s_q;                  // Registered state
   lcr_st_t                s_d;                  // Next state
   logic [PAL_W-1:0]       pal_mem [PAL_ENTRIES]; // Palette storage
   logic                   acc;                  // Address phase taken
   logic                   wr_ok;                // Word write in data phase
   logic                   pal_we;               // Palette write strobe
   logic [ST_W-1:0]        ev_set;               // Events this cycle
   logic [ST_W-1:0]        irq_mask;             // Mask per flag
   logic [31:0]            rd_val;               // Decoded read value
   logic [31:0]            c0_new;               // Written control word
   logic                   dma_hit;              // Address in DMA block
   logic [3:0]             dma_idx;              // DMA word index
   logic                   toggled;              // Bias pin edge
   logic [BIAS_W-1:0]      bias_lim;             // Programmed toggles

   lcr_pal_if pal ();                            // Spacer link

   // Palette request spacing sits in its own small counter
   assign pal.req         = pal_fetch_req;
   assign pal.spacing     = s_q.ctrl0[C0_SPACE_LSB +: SPACE_W];
   assign pal_fetch_grant = pal.grant;

   lcr_spacer u_spacer
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .p       (pal)
   );

   // Bus handshake: one wait state on reads only, always OKAY
   assign acc       = hsel && htrans[1] && hready;
   assign hreadyout = (s_q.bus != BUS_RD_WAIT);
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;
   assign wr_ok     = (s_q.bus == BUS_WR) && s_q.size_ok;
   assign c0_new    = hwdata & C0_WR_MASK;
   assign dma_hit   = (s_q.addr >= OFF_DMA_BASE) &&
                      (s_q.addr < OFF_DMA_BASE + 12'(4 * DMA_REGS));
   assign dma_idx   = 4'((s_q.addr - OFF_DMA_BASE) >> 2);
   assign pal_we    = wr_ok && (s_q.addr >= OFF_PAL_BASE);

   // Register outputs toward the display engine
   assign display_control_0 = s_q.ctrl0 | (32'(s_q.dis) << C0_DIS);
   assign display_control_1 = s_q.ctrl1;
   assign display_control_2 = s_q.ctrl2;
   assign display_control_3 = s_q.ctrl3;
   assign dma_regs          = s_q.dma;
   assign controller_on     = s_q.ctrl0[C0_ON];

   // Engine events gathered into flag positions
   always_comb
   begin
      ev_set              = '0;
      ev_set[ST_IN_OVR]   = ev_in_fifo_overrun;
      ev_set[ST_IN_UNR]   = ev_in_fifo_underrun;
      ev_set[ST_OUT_OVR]  = ev_out_fifo_overrun;
      ev_set[ST_OUT_UNR]  = ev_out_fifo_underrun;
      ev_set[ST_BUS_ERR]  = ev_bus_error;
      ev_set[ST_FR_START] = ev_frame_start;
      ev_set[ST_FR_END]   = ev_frame_end;
      ev_set[ST_BRANCH]   = ev_branch_start;
      ev_set[ST_QDIS]     = ev_quick_disable;
      ev_set[ST_DIS_DONE] = s_q.pend && ev_last_frame_out;
      ev_set[ST_BIAS]     = toggled && (bias_lim != '0) &&
                            (s_q.bias_cnt + 8'h01 == bias_lim);
   end

   // Mask bits per flag; unmaskable flags always request
   always_comb
   begin
      irq_mask              = '0;
      irq_mask[ST_OUT_UNR]  = s_q.ctrl0[C0_OUM];
      irq_mask[ST_BRANCH]   = s_q.ctrl0[C0_BM];
      irq_mask[ST_QDIS]     = s_q.ctrl0[C0_QDM];
      irq_mask[ST_FR_END]   = s_q.ctrl0[C0_EFM];
      irq_mask[ST_IN_UNR]   = s_q.ctrl0[C0_IUM];
      irq_mask[ST_FR_START] = s_q.ctrl0[C0_SFM];
      irq_mask[ST_DIS_DONE] = s_q.ctrl0[C0_LDM];
   end

   // Masks only gate the request, flags keep their value
   assign irq = |(s_q.status & ~irq_mask);

   assign toggled  = bias_pin ^ s_q.bias_prev;
   assign bias_lim = s_q.ctrl3[C3_BIAS_LSB +: BIAS_W];

   // Read decode; every address from 0x400 up reads the palette, other unmapped addresses read as zero
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (s_q.addr >= OFF_PAL_BASE)
      begin
         rd_val = 32'(pal_mem[s_q.addr[9:2]]);
      end
      else if (dma_hit)
      begin
         rd_val = s_q.dma[dma_idx];
      end
      else
      begin
         case (s_q.addr)
            OFF_CTRL0:  rd_val = display_control_0;
            OFF_CTRL1:  rd_val = s_q.ctrl1;
            OFF_CTRL2:  rd_val = s_q.ctrl2;
            OFF_CTRL3:  rd_val = s_q.ctrl3;
            OFF_STATUS: rd_val = 32'(s_q.status);
            default:    rd_val = 32'h0000_0000;
         endcase
      end
   end

   // Next-state logic for bus, registers, flags and counters
   always_comb
   begin
      s_d           = s_q;
      s_d.bias_prev = bias_pin;

      // Bus phase sequencing
      case (s_q.bus)
         BUS_RD_WAIT:
         begin
            s_d.rdata = rd_val;
            s_d.bus   = BUS_RD_OUT;
         end
         default:
         begin
            s_d.bus = BUS_IDLE;
         end
      endcase
      if (acc)
      begin
         s_d.bus     = hwrite ? BUS_WR : BUS_RD_WAIT;
         s_d.addr    = haddr[ADDR_W-1:0];
         s_d.size_ok = (hsize == HSIZE_WORD);
      end

      // Hardware loads DMA registers from descriptors
      if (dma_load_en && (32'(dma_load_idx) < DMA_REGS))
      begin
         s_d.dma[dma_load_idx] = dma_load_data;
      end

      // Bias toggle counter
      if (toggled && (bias_lim != '0))
      begin
         if (ev_set[ST_BIAS])
         begin
            s_d.bias_cnt = '0;
         end
         else
         begin
            s_d.bias_cnt = s_q.bias_cnt + 8'h01;
         end
      end

      // Last frame out ends the disable sequence
      if (ev_set[ST_DIS_DONE])
      begin
         s_d.pend = 1'b0;
      end

      // Register writes in the data phase
      if (wr_ok)
      begin
         case (s_q.addr)
            OFF_CTRL0:
            begin
               s_d.ctrl0 = c0_new;
               if (s_q.ctrl0[C0_ON] && !c0_new[C0_ON])
               begin
                  s_d.dis  = 1'b1;
                  s_d.pend = 1'b1;
               end
               else if (c0_new[C0_ON])
               begin
                  s_d.dis  = 1'b0;
                  s_d.pend = 1'b0;
               end
            end
            OFF_CTRL1:  s_d.ctrl1 = hwdata;
            OFF_CTRL2:  s_d.ctrl2 = hwdata;
            OFF_CTRL3:  s_d.ctrl3 = hwdata;
            OFF_STATUS: s_d.status = s_q.status & ~hwdata[ST_W-1:0];
            default:
            begin
               // Software reaches only the descriptor addresses
               if (dma_hit && (dma_idx == DMA_DESC_CH0 || dma_idx == DMA_DESC_CH1)
                   && !(dma_load_en && dma_load_idx == dma_idx))
               begin
                  s_d.dma[dma_idx] = hwdata;
               end
            end
         endcase
      end

      // Events set after any clear, so a set is never lost
      s_d.status = s_d.status | ev_set;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q        <= '0;
         s_q.bus    <= BUS_IDLE;
         s_q.ctrl0  <= CTRL_RST;
         s_q.ctrl1  <= CTRL_RST;
         s_q.ctrl2  <= CTRL_RST;
         s_q.ctrl3  <= CTRL_RST;
         s_q.status <= STATUS_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Palette array, written by software, read by the engine
   always_ff @(posedge hclk)
   begin
      if (pal_we)
      begin
         pal_mem[s_q.addr[9:2]] <= hwdata[PAL_W-1:0];
      end
   end

   // Engine palette read port
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pal_rd_data <= '0;
      end
      else
      begin
         pal_rd_data <= pal_mem[pal_rd_idx];
      end
   end

   AST_CTRL0_WORD: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ok && s_q.addr == OFF_CTRL0) |=>
      ((display_control_0 & C0_WR_MASK) == ($past(hwdata) & C0_WR_MASK)))
      else $error("control word write not stored whole");

   AST_READ_TIMING: assert property (@(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite) |=> !hreadyout ##1 (hreadyout && hrdata == $past(rd_val)))
      else $error("read wait state missing or extra");

   AST_BUS_ERR_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_bus_error |=> s_q.status[ST_BUS_ERR])
      else $error("bus error flag not set");

   AST_FRAME_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn)
      (ev_frame_start || ev_frame_end) |=>
      ((s_q.status[ST_FR_START] || !$past(ev_frame_start)) &&
       (s_q.status[ST_FR_END] || !$past(ev_frame_end))))
      else $error("frame start or end flag not set");

   AST_DIS_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_q.pend && ev_last_frame_out) |=> (s_q.status[ST_DIS_DONE] && !s_q.pend))
      else $error("disable done flag not set after last frame");

   AST_OUT_UNR_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_q.status[ST_OUT_UNR] && !s_q.ctrl0[C0_OUM]) |-> irq)
      else $error("unmasked output underrun raised no request");

   AST_BRANCH_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_q.status == (ST_W'(1) << ST_BRANCH) && s_q.ctrl0[C0_BM]) |-> !irq)
      else $error("masked branch start raised a request");

   AST_MASK_KEEPS_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_q.ctrl0[C0_OUM] && ev_out_fifo_underrun) |=> s_q.status[ST_OUT_UNR])
      else $error("mask suppressed the underrun flag");

   AST_DMA_HW_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ok && dma_hit && dma_idx != DMA_DESC_CH0 && dma_idx != DMA_DESC_CH1
       && !dma_load_en) |=> $stable(s_q.dma))
      else $error("software changed a hardware-loaded DMA register");

   AST_DISABLE_SHOWS: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ok && s_q.addr == OFF_CTRL0 && s_q.ctrl0[C0_ON] && !hwdata[C0_ON])
      |=> (!controller_on && display_control_0[C0_DIS]))
      else $error("disable not reflected in control register");

endmodule

// *** dv/lcr_engine_model.sv ***
/*
   Display engine stand-in: turns bench strobes into one-cycle event
   pulses and toggles the bias pin.
   Assumes strobes are driven just after a rising hclk edge.
*/
`timescale 1ns/1ps
module lcr_engine_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [10:0] kick,
   output logic      [9:0]  ev,
   output logic             bias_pin
);
   // Registered pulses, bias flips once per strobe
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ev       <= '0;
         bias_pin <= 1'b0;
      end
      else
      begin
         ev       <= kick[9:0];
         bias_pin <= bias_pin ^ kick[10];
      end
   end
endmodule

// *** dv/tb_top.sv ***
/*
   Self-checking bench for the register bank over AHB-Lite.
   Assumes one slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module tb_top;
   import lcr_pkg::*;
   localparam logic [31:0] MASKS = 32'h0030_0878; // All irq masks set
   localparam int ST_MAP [9] = '{0, 1, 2, 3, 4, 5, 6, 9, 10};
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic             hsel = 1'b0;
   logic             hwrite = 1'b0;
   logic [31:0]      haddr = '0;
   logic [31:0]      hwdata = '0;
   logic [1:0]       htrans = '0;
   logic [2:0]       hsize = HSIZE_WORD;
   logic [10:0]      kick = '0;          // Strobes to the engine model
   logic [9:0]       ev;
   logic             bias_pin, hreadyout, hresp, grant, on, irq;
   logic             ld_en = 1'b0;
   logic             pal_req = 1'b0;
   logic [3:0]       ld_idx = '0;
   logic [31:0]      ld_data = '0;
   logic [31:0]      hrdata, dc0, dc1, dc2, dc3;
   logic [9:0][31:0] dmar;               // DMA register outputs
   logic [PAL_W-1:0] pal_rd_data;
   logic [31:0]      exp_q[$];           // Expected read data, oldest first
   logic             rd_dp = 1'b0;
   int               err_total = 0;
   int               n_tests = 0;

   always #25 hclk = ~hclk;

   lcr_engine_model eng (.hclk(hclk), .hresetn(hresetn), .kick(kick), .ev(ev),
      .bias_pin(bias_pin));

   lcr_bank uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ev_in_fifo_overrun(ev[0]), .ev_in_fifo_underrun(ev[1]),
      .ev_out_fifo_overrun(ev[2]), .ev_out_fifo_underrun(ev[3]),
      .ev_bus_error(ev[4]), .ev_frame_start(ev[5]), .ev_frame_end(ev[6]),
      .ev_branch_start(ev[7]), .ev_quick_disable(ev[8]),
      .ev_last_frame_out(ev[9]), .bias_pin(bias_pin), .dma_load_en(ld_en),
      .dma_load_idx(ld_idx), .dma_load_data(ld_data), .pal_fetch_req(pal_req),
      .pal_fetch_grant(grant), .pal_rd_idx(8'hff), .pal_rd_data(pal_rd_data),
      .display_control_0(dc0), .display_control_1(dc1), .display_control_2(dc2),
      .display_control_3(dc3), .dma_regs(dmar), .controller_on(on), .irq(irq));

   // Compare and count one result
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Counts, verdict, end of run
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // One single word transfer; on a read d is the expected data
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      hsel   <= 1'b1;
      haddr  <= 32'(a);
      hwrite <= w;
      do @(posedge hclk); while (!hreadyout);
      htrans <= 2'b00;
      hwdata <= d;
      if (!w)
         exp_q.push_back(d);
      do @(posedge hclk); while (!hreadyout);
   endtask

   // One strobe to the model, then let the flag settle
   task automatic pulse(input int i);
      kick <= 11'(1) << i;
      @(posedge hclk);
      kick <= '0;
      repeat (3) @(posedge hclk);
   endtask

   // Read data monitor: takes the oldest note when a read completes
   always @(posedge hclk)
   begin
      if (rd_dp && hreadyout)
      begin
         chk("hrdata", exp_q.pop_front(), hrdata);
         chk("hresp", 0, 32'(hresp));
         rd_dp = 1'b0;
      end
      if (hsel && htrans[1] && !hwrite && hreadyout)
         rd_dp = 1'b1;
   end

   // Watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge hclk);
      err_total++;
      final_report();
   end

   // Main sequence
   initial
   begin
      int unsigned r, s, last, cyc;
      void'($urandom(28));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("on", 0, 32'(on));
      xfer(0, OFF_CTRL0, CTRL_RST);
      xfer(0, OFF_STATUS, 32'(STATUS_RST));
      // Other control registers are set up before any enable
      r = $urandom;
      xfer(1, OFF_CTRL1, r);
      xfer(1, OFF_CTRL2, ~r);
      xfer(1, OFF_CTRL3, 0);
      xfer(0, OFF_CTRL1, r);
      chk("ctrl1", r, dc1);
      chk("ctrl2", ~r, dc2);
      // Whole-word configure with enable, then disable
      repeat (3)
      begin
         r = ($urandom & C0_WR_MASK) | 32'h1;
         xfer(1, OFF_CTRL0, r);
         xfer(0, OFF_CTRL0, r);
         chk("ctrl0", r, dc0);
         chk("on", 1, 32'(on));
         xfer(1, OFF_CTRL0, 0);
         xfer(0, OFF_CTRL0, 32'h400);
      end
      // Each event: flag under mask, irq once unmasked, clear
      xfer(1, OFF_CTRL0, MASKS);
      for (int i = 0; i < 9; i++)
      begin
         pulse(i);
         xfer(0, OFF_STATUS, 32'h1 << ST_MAP[i]);
         chk("irq masked", 32'(i == 0 || i == 2 || i == 4), 32'(irq));
         xfer(1, OFF_CTRL0, 0);
         @(posedge hclk);
         chk("irq open", 1, 32'(irq));
         xfer(1, OFF_STATUS, 32'h7ff);
         xfer(0, OFF_STATUS, 0);
         chk("irq clear", 0, 32'(irq));
         xfer(1, OFF_CTRL0, MASKS);
      end
      // Disable done only while a disable is pending
      pulse(9);
      xfer(0, OFF_STATUS, 32'h80);
      xfer(1, OFF_STATUS, 32'h7ff);
      pulse(9);
      xfer(0, OFF_STATUS, 0);
      xfer(1, OFF_CTRL0, 1);
      xfer(1, OFF_CTRL0, 0);
      pulse(9);
      xfer(0, OFF_STATUS, 32'h80);
      xfer(1, OFF_STATUS, 32'h7ff);
      // Bias flag after three toggles
      xfer(1, OFF_CTRL3, 3);
      repeat (2) pulse(10);
      xfer(0, OFF_STATUS, 0);
      pulse(10);
      xfer(0, OFF_STATUS, 32'h100);
      // Descriptor write, read-only DMA word, hardware load
      r = $urandom & 32'hffff_fff8;
      xfer(1, OFF_DMA_BASE, r);
      xfer(0, OFF_DMA_BASE, r);
      xfer(1, OFF_DMA_BASE + 12'h004, r);
      xfer(0, OFF_DMA_BASE + 12'h004, 0);
      ld_idx  <= 4'h3;
      ld_data <= ~r;
      ld_en   <= 1'b1;
      @(posedge hclk);
      ld_en <= 1'b0;
      xfer(0, OFF_DMA_BASE + 12'h00c, ~r);
      chk("dma3", ~r, dmar[3]);
      // Last palette entry, then the fourth control register
      xfer(1, OFF_PAL_BASE + 12'h3fc, r);
      xfer(0, OFF_PAL_BASE + 12'h3fc, r & 32'hffff);
      chk("pal", r & 32'hffff, 32'(pal_rd_data));
      xfer(0, OFF_CTRL3, 32'h3);
      chk("ctrl3", 32'h3, dc3);
      // Palette grants spaced by the programmed gap
      s = $urandom_range(6, 1);
      xfer(1, OFF_CTRL0, s << 12);
      pal_req <= 1'b1;
      last = 0;
      cyc = 0;
      repeat (30)
      begin
         @(posedge hclk);
         cyc++;
         if (grant)
         begin
            if (last != 0)
               chk("gap", s + 1, cyc - last);
            last = cyc;
         end
      end
      pal_req <= 1'b0;
      // Reset in mid-run returns the control word to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("ctrl0 rst", 0, dc0);
      chk("on rst", 0, 32'(on));
      xfer(0, OFF_CTRL0, CTRL_RST);
      final_report();
   end
endmodule
